// ===== logic/flash_prog_consts.vh
`ifndef FLASH_PROG_CONSTS_VH
`define FLASH_PROG_CONSTS_VH
// command codes written on the data lines
`define CMD_READ        8'h00
`define CMD_ERASE       8'h20
`define CMD_ERASE_VFY   8'hA0
`define CMD_PROGRAM     8'h40
`define CMD_PROG_VFY    8'hC0
`define CMD_RESET       8'hFF
// data values
`define ERASED_BYTE     8'hFF
`define ZERO_BYTE       8'h00
`define FIRST_ADDR      16'h0000
`define LAST_ADDR       16'hFFFF
// retry limits
`define PROG_MAX_TRIES  5'd25
`define ERASE_MAX_STD   13'd1000
`define ERASE_MAX_EXT   13'd6000
// timing, clock 100 MHz
`define CLK_MHZ         100
`define PROG_PULSE_NS   10000
`define ERASE_TIME_NS   9500000
`define PROG_WAIT_CYC   (`PROG_PULSE_NS * `CLK_MHZ / 1000)
`define ERASE_WAIT_CYC  (`ERASE_TIME_NS * `CLK_MHZ / 1000)
// bus cycle phase counter loads; each phase lasts one cycle more
`define WR_SETUP_CYC    4'd2
`define WR_PULSE_CYC    4'd8
`define WR_HOLD_CYC     4'd3
`define RD_ACCESS_CYC   4'd15
`define WR_TO_RD_CYC    10'd600
`endif

// ===== logic/flash_prog_host.v
// Contract
// - host programs all bytes to 00h before erase
// - erase armed by 20h, started by second 20h
// - 0A0h with address, then read, compare 0FFh
// - erase verify starts at 0000h, walks upward
// - on fail, save address, re-erase, resume
// - erase attempts capped 1000, or 6000 extended
// - 10us pulses repeated until verify passes
// - at most 25 program attempts per byte
// - 40h arms, next write latches address/data
// - 0C0h then read, compare with intended data
// - wait 10us before program verify write
// - wait 9.5ms before erase verify write
// - writes framed by chip select and strobe
`timescale 1ns/1ps
`include "flash_prog_consts.vh"
module flash_prog_host #(
	parameter ERASE_WAIT = `ERASE_WAIT_CYC	// erase settle cycles
) (
	input  wire        ref_clk,        // 100 MHz clock
	input  wire        reset,          // synchronous, active high
	input  wire        clk_en,         // freezes all state when low
	input  wire        start_prog,     // pulse: program one byte
	input  wire        start_erase,    // pulse: full chip erase
	input  wire        ext_grade,      // high selects 6000 erase limit
	input  wire [15:0] prog_addr,      // byte address to program
	input  wire [7:0]  prog_data,      // byte value to program
	output wire        busy,           // sequence running
	output reg         done_q,         // pulse: sequence ended
	output reg         fail_q,         // pulse with done: failure
	output reg         erase_fail_q,   // level: last fail was erase
	output reg  [15:0] address_lines,  // flash address
	input  wire [7:0]  data_in,        // flash data lines, input
	output reg  [7:0]  data_lines,     // flash data lines, output
	output reg         data_oe_n_q,    // low while driving data lines
	output reg         chip_sel_n_q,   // flash chip select
	output reg         wr_n_q,         // flash write strobe
	output reg         rd_n_q          // flash output enable
);
	// top-level states
	localparam S_IDLE    = 4'd0;
	localparam S_PZ_NEXT = 4'd1;  // step to next byte of the 00h pre-program, or to erase after the last
	localparam S_P_ARM   = 4'd2;
	localparam S_P_DATA  = 4'd3;
	localparam S_P_WAIT  = 4'd4;
	localparam S_P_VFY   = 4'd5;
	localparam S_P_READ  = 4'd6;
	localparam S_E_ARM   = 4'd7;
	localparam S_E_GO    = 4'd8;
	localparam S_E_WAIT  = 4'd9;
	localparam S_E_VFY   = 4'd10;
	localparam S_E_READ  = 4'd11;
	localparam S_RST1    = 4'd12;
	localparam S_RST2    = 4'd13;
	localparam S_END     = 4'd14;
	// bus cycle phases
	localparam B_IDLE  = 3'd0;
	localparam B_SETUP = 3'd1;
	localparam B_PULSE = 3'd2;
	localparam B_HOLD  = 3'd3;
	localparam B_READ  = 3'd4;
	localparam B_GAP   = 3'd5;

	localparam [23:0] PROG_WAIT = `PROG_WAIT_CYC;

	reg [3:0]  st_q;
	reg [2:0]  bph_q;
	reg [9:0]  bcnt_q;
	reg        bdone_q;       // pulse: bus cycle complete
	reg [23:0] wait_q;
	reg [15:0] addr_q;        // current byte address
	reg [7:0]  want_q;        // data expected at verify
	reg [4:0]  ptry_q;
	reg [12:0] etry_q;
	reg        erase_mode_q;  // pre-program is part of an erase
	reg        fail_pend_q;
	reg [7:0]  rdata_q;

	assign busy = (st_q != S_IDLE);

	// true when state issues a write cycle
	function is_write;
		input [3:0] s;
		begin
			is_write = (s == S_P_ARM) || (s == S_P_DATA) || (s == S_P_VFY) ||
				(s == S_E_ARM) || (s == S_E_GO) || (s == S_E_VFY) ||
				(s == S_RST1) || (s == S_RST2);
		end
	endfunction

	// true when state issues a read cycle
	function is_read;
		input [3:0] s;
		begin
			is_read = (s == S_P_READ) || (s == S_E_READ);
		end
	endfunction

	// bus cycle engine: chip select frames strobe fully, wider than it
	always @(posedge ref_clk) begin
		if (reset) begin
			bph_q <= B_IDLE;
			bcnt_q <= 10'd0;
			bdone_q <= 1'b0;
			chip_sel_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			data_oe_n_q <= 1'b1;
			rdata_q <= 8'h00;
		end else if (clk_en) begin
			bdone_q <= 1'b0;
			case (bph_q)
			B_IDLE: begin
				if (!bdone_q && (is_write(st_q) || is_read(st_q))) begin
					chip_sel_n_q <= 1'b0;
					data_oe_n_q <= ~is_write(st_q);
					bcnt_q <= {6'd0, `WR_SETUP_CYC};
					bph_q <= is_write(st_q) ? B_SETUP : B_READ;
					if (is_read(st_q)) begin
						rd_n_q <= 1'b0;
						bcnt_q <= {6'd0, `RD_ACCESS_CYC};
					end
				end
			end
			B_SETUP: begin
				if (bcnt_q == 10'd0) begin
					wr_n_q <= 1'b0;
					bcnt_q <= {6'd0, `WR_PULSE_CYC};
					bph_q <= B_PULSE;
				end else
					bcnt_q <= bcnt_q - 10'd1;
			end
			B_PULSE: begin
				if (bcnt_q == 10'd0) begin
					wr_n_q <= 1'b1; // rising edge latches data
					bcnt_q <= {6'd0, `WR_HOLD_CYC};
					bph_q <= B_HOLD;
				end else
					bcnt_q <= bcnt_q - 10'd1;
			end
			B_HOLD: begin
				if (bcnt_q == 10'd0) begin
					chip_sel_n_q <= 1'b1;
					data_oe_n_q <= 1'b1;
					bcnt_q <= `WR_TO_RD_CYC; // strobe high to output enable gap
					bph_q <= B_GAP;
				end else
					bcnt_q <= bcnt_q - 10'd1;
			end
			B_READ: begin
				if (bcnt_q == 10'd0) begin
					rdata_q <= data_in;
					rd_n_q <= 1'b1;
					chip_sel_n_q <= 1'b1;
					bcnt_q <= 10'd2;
					bph_q <= B_GAP;
				end else
					bcnt_q <= bcnt_q - 10'd1;
			end
			B_GAP: begin
				if (bcnt_q == 10'd0) begin
					bdone_q <= 1'b1;
					bph_q <= B_IDLE;
				end else
					bcnt_q <= bcnt_q - 10'd1;
			end
			default: bph_q <= B_IDLE;
			endcase
		end
	end

	// address and data presented for each command write
	always @(posedge ref_clk) begin
		if (reset) begin
			address_lines <= 16'h0000;
			data_lines <= 8'h00;
		end else if (clk_en && bph_q == B_IDLE) begin
			address_lines <= addr_q;
			case (st_q)
			S_P_ARM:  data_lines <= `CMD_PROGRAM;
			S_P_DATA: data_lines <= want_q;
			S_P_VFY:  data_lines <= `CMD_PROG_VFY;
			S_E_ARM:  data_lines <= `CMD_ERASE;
			S_E_GO:   data_lines <= `CMD_ERASE;
			S_E_VFY:  data_lines <= `CMD_ERASE_VFY;
			S_RST1:   data_lines <= `CMD_RESET;
			S_RST2:   data_lines <= `CMD_RESET;
			default:  data_lines <= data_lines;
			endcase
		end
	end

	// algorithm sequencer
	always @(posedge ref_clk) begin
		if (reset) begin
			st_q <= S_IDLE;
			wait_q <= 24'd0;
			addr_q <= 16'h0000;
			want_q <= 8'h00;
			ptry_q <= 5'd0;
			etry_q <= 13'd0;
			erase_mode_q <= 1'b0;
			fail_pend_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			erase_fail_q <= 1'b0;
		end else if (clk_en) begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
			case (st_q)
			S_IDLE: begin
				ptry_q <= 5'd0;
				etry_q <= 13'd0;
				fail_pend_q <= 1'b0;
				if (start_erase) begin
					erase_mode_q <= 1'b1;
					addr_q <= `FIRST_ADDR;
					want_q <= `ZERO_BYTE;
					st_q <= S_P_ARM;
				end else if (start_prog) begin
					erase_mode_q <= 1'b0;
					addr_q <= prog_addr;
					want_q <= prog_data;
					st_q <= S_P_ARM;
				end
			end
			S_PZ_NEXT: begin
				ptry_q <= 5'd0;
				if (addr_q == `LAST_ADDR) begin
					addr_q <= `FIRST_ADDR;
					st_q <= S_E_ARM;
				end else begin
					addr_q <= addr_q + 16'd1;
					st_q <= S_P_ARM;
				end
			end
			S_P_ARM:  if (bdone_q) st_q <= S_P_DATA;
			S_P_DATA: if (bdone_q) begin
				ptry_q <= ptry_q + 5'd1;
				wait_q <= PROG_WAIT;
				st_q <= S_P_WAIT;
			end
			S_P_WAIT: begin
				if (wait_q == 24'd0)
					st_q <= S_P_VFY;
				else
					wait_q <= wait_q - 24'd1;
			end
			S_P_VFY:  if (bdone_q) st_q <= S_P_READ;
			S_P_READ: if (bdone_q) begin
				if (rdata_q == want_q) begin
					if (erase_mode_q)
						st_q <= S_PZ_NEXT;
					else
						st_q <= S_END;
				end else if (ptry_q >= `PROG_MAX_TRIES) begin
					fail_pend_q <= 1'b1;
					erase_fail_q <= 1'b0;
					st_q <= S_RST1;
				end else
					st_q <= S_P_ARM;
			end
			S_E_ARM: if (bdone_q) st_q <= S_E_GO;
			S_E_GO: if (bdone_q) begin
				etry_q <= etry_q + 13'd1;
				wait_q <= ERASE_WAIT[23:0];
				st_q <= S_E_WAIT;
			end
			S_E_WAIT: begin
				if (wait_q == 24'd0)
					st_q <= S_E_VFY;
				else
					wait_q <= wait_q - 24'd1;
			end
			S_E_VFY:  if (bdone_q) st_q <= S_E_READ;
			S_E_READ: if (bdone_q) begin
				if (rdata_q == `ERASED_BYTE) begin
					if (addr_q == `LAST_ADDR)
						st_q <= S_END;
					else begin
						addr_q <= addr_q + 16'd1;
						st_q <= S_E_VFY;
					end
				end else if (etry_q >= (ext_grade ? `ERASE_MAX_EXT : `ERASE_MAX_STD)) begin
					fail_pend_q <= 1'b1;
					erase_fail_q <= 1'b1;
					st_q <= S_RST1;
				end else
					st_q <= S_E_ARM; // addr_q keeps failing byte
			end
			S_RST1: if (bdone_q) st_q <= S_RST2;
			S_RST2: if (bdone_q) st_q <= S_END;
			S_END: begin
				done_q <= 1'b1;
				fail_q <= fail_pend_q;
				st_q <= S_IDLE;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== test/flash_chk_sva.sv
`timescale 1ns/1ps
module flash_chk (
	input wire        ref_clk,       // clock
	input wire        reset,         // sync reset
	input wire        start_prog,    // program request
	input wire        busy,          // running
	input wire        done_q,        // end pulse
	input wire        fail_q,        // failure flag
	input wire [15:0] address_lines, // flash address
	input wire [7:0]  data_lines,    // host data
	input wire        data_oe_n_q,   // data drive
	input wire        chip_sel_n_q,  // chip select
	input wire        wr_n_q,        // write strobe
	input wire        rd_n_q         // output enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	reg [10:0] gap_q;
	// cycles since the last strobe release
	always @(posedge ref_clk) begin
		if (reset || $rose(wr_n_q))
			gap_q <= 11'h000;
		else if (gap_q != 11'h7FF)
			gap_q <= gap_q + 11'h001;
	end
	sequence s_pulse;
		!wr_n_q[*8] ##1 !wr_n_q ##1 wr_n_q;
	endsequence
	sequence s_vfy;
		$fell(wr_n_q) && data_lines == 8'hC0;
	endsequence
	wr_sel_a: assert property (!wr_n_q |-> !chip_sel_n_q && !data_oe_n_q)
		else $error("strobe outside select");
	rd_wr_a: assert property (!rd_n_q |-> wr_n_q && data_oe_n_q)
		else $error("read during write");
	wr_width_a: assert property ($fell(wr_n_q) |-> s_pulse)
		else $error("strobe width wrong");
	wr_hold_a: assert property (!wr_n_q ##1 !wr_n_q |-> $stable({data_lines, address_lines}))
		else $error("bus moved under strobe");
	vfy_gap_a: assert property (s_vfy |-> gap_q >= 11'h3E8)
		else $error("verify too early");
	fail_done_a: assert property (fail_q |-> done_q)
		else $error("fail without done");
	done_one_a: assert property (done_q |=> !done_q)
		else $error("done too long");
	start_take_a: assert property (start_prog && !busy |=> busy)
		else $error("start not taken");
endmodule

// ===== test/flash_model.sv
`timescale 1ns/1ps
module flash_model (
	input  wire [15:0] addr, // address lines
	input  wire [7:0]  din,  // host data
	input  wire        cs_n, // chip select
	input  wire        wr_n, // write strobe
	input  wire        rd_n, // output enable
	input  wire [7:0]  need, // pulses a byte needs
	output reg  [7:0]  dout  // data to host
);
	reg [7:0]  mem [0:65535];
	reg [7:0]  cmd = 8'h00;
	reg [15:0] la = 16'h0000;
	int        tries = 0;
	int        pulses = 0;
	initial foreach (mem[i]) mem[i] = 8'hFF;
	initial dout = 8'h00;
	// decode on the closing strobe edge
	always @(posedge wr_n) if (!cs_n) begin
		if (cmd == 8'h40) begin
			if (addr != la)
				tries = 0;
			la = addr;
			tries++;
			pulses++;
			if (tries >= need)
				mem[addr] = mem[addr] & din;
			cmd = 8'h41;
		end else if (cmd == 8'h20 && din == 8'h20) begin
			foreach (mem[i]) mem[i] = 8'hFF;
			cmd = 8'h21;
		end else if (cmd == 8'hFF && din == 8'hFF)
			cmd = 8'h00;
		else begin
			cmd = din;
			if (din == 8'hA0)
				la = addr;
		end
	end
	// verify reads the latched byte
	always @(negedge rd_n) dout = (cmd == 8'hC0 || cmd == 8'hA0) ? mem[la] : mem[addr];
	// released bus shows the inverse
	always @(posedge rd_n) dout = ~dout;
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	reg         ref_clk, reset, start_prog, start_erase, ext_grade, clk_en;
	reg  [15:0] prog_addr;
	reg  [7:0]  prog_data, need;
	wire [15:0] address_lines;
	wire [7:0]  data_in, data_lines;
	wire        busy, done_q, fail_q, erase_fail_q, oe_n, cs_n, wr_n, rd_n;
	int         failures = 0;
	int         total_checks = 0;
	int         base = 0;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	flash_prog_host #(.ERASE_WAIT(20)) dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.start_prog(start_prog), .start_erase(start_erase), .ext_grade(ext_grade),
		.prog_addr(prog_addr), .prog_data(prog_data), .busy(busy), .done_q(done_q),
		.fail_q(fail_q), .erase_fail_q(erase_fail_q), .address_lines(address_lines),
		.data_in(data_in), .data_lines(data_lines), .data_oe_n_q(oe_n),
		.chip_sel_n_q(cs_n), .wr_n_q(wr_n), .rd_n_q(rd_n));
	flash_model fm (.addr(address_lines), .din(data_lines), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .need(need), .dout(data_in));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task give_verdict;
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one byte program with a refused start in mid-run
	task run(input [7:0] n);
		int k;
		reg [15:0] a;
		reg [7:0] d;
		a = 16'($urandom);
		d = 8'($urandom) & 8'hFE;
		need = n;
		prog_addr <= a;
		prog_data <= d;
		ext_grade <= 1'($urandom);
		start_prog <= 1'b1;
		exp_q.push_back({n > 8'h19, (n > 8'h19) ? 8'h19 : n});
		@(posedge ref_clk);
		start_prog <= 1'b0;
		repeat (50) @(posedge ref_clk);
		start_prog <= 1'b1;
		start_erase <= 1'b1;
		prog_addr <= ~a;
		@(posedge ref_clk);
		start_prog <= 1'b0;
		start_erase <= 1'b0;
		for (k = 0; k < 80000 && busy !== 1'b0; k++) @(posedge ref_clk);
		if (k == 80000) begin
			failures++;
			give_verdict();
		end
		@(posedge ref_clk);
		if (n <= 8'h19) `CHK("byte", d, fm.mem[a])
	endtask
	// erase cut short: first byte zero filled, a freeze in the wait, then a reset
	task erase_cut;
		need = 8'h01;
		start_erase <= 1'b1;
		@(posedge ref_clk);
		start_erase <= 1'b0;
		repeat (1300) @(posedge ref_clk);
		clk_en <= 1'b0;
		repeat (200) @(posedge ref_clk);
		clk_en <= 1'b1;
		`CHK("zero fill", 8'h00, fm.mem[0])
		repeat (750) @(posedge ref_clk);
		`CHK("frozen wait", 1'b1, cs_n)
		repeat (200) @(posedge ref_clk);
		`CHK("verify write", 1'b0, cs_n)
		repeat (50) @(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		`CHK("reset idle", 2'b01, {busy, cs_n})
		base = fm.pulses;
	endtask
	// each done pulse is matched with the oldest note
	always @(posedge ref_clk) if (done_q === 1'b1) begin
		if (exp_q.size() == 0) `CHK("done", 1'b0, 1'b1)
		else begin
			e = exp_q.pop_front();
			`CHK("fail", e[8], fail_q)
			`CHK("pulses", e[7:0], 8'(fm.pulses - base))
			if (e[8]) `CHK("erase flag", 1'b0, erase_fail_q)
			if (e[8]) `CHK("cmd", 8'h00, fm.cmd)
			base = fm.pulses;
		end
	end
	initial begin
		void'($urandom(32'h9AEC));
		{reset, start_prog, start_erase, ext_grade} = 4'hF;
		{start_prog, start_erase, ext_grade, clk_en} = 4'h1;
		prog_addr = 16'h0000;
		prog_data = 8'h00;
		need = 8'h01;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		run(8'h01);
		erase_cut();
		run(8'h03);
		run(8'h1E);
		`CHK("pending", 0, exp_q.size())
		give_verdict();
	end
endmodule
bind flash_prog_host flash_chk chk (.ref_clk(ref_clk), .reset(reset), .start_prog(start_prog),
	.busy(busy), .done_q(done_q), .fail_q(fail_q), .address_lines(address_lines),
	.data_lines(data_lines), .data_oe_n_q(data_oe_n_q), .chip_sel_n_q(chip_sel_n_q),
	.wr_n_q(wr_n_q), .rd_n_q(rd_n_q));
